//--- rtl/adcob_defs.svh
// Constants for the converter control-byte and overtemperature alarm block.
`ifndef ADCOB_DEFS_SVH
`define ADCOB_DEFS_SVH
// Control byte width and the split between selector and threshold fields.
`define ADCOB_BYTE_BITS 8
`define ADCOB_SEL_MSB   2
`define ADCOB_HI_LSB    3
// Reset values: temperature sensor selected, alarm at 50 degrees (50 + 103).
`define ADCOB_CHAN_RST  3'h0
`define ADCOB_THR_RST   8'h99
// Channel codes with special meaning.
`define ADCOB_CHAN_TEMP 3'h0
`define ADCOB_CHAN_REF  3'h7
`define ADCOB_CHAN_NA1  3'h5
`define ADCOB_CHAN_NA2  3'h6
// Code produced for the internal bandgap selection, midscale of 10 bits.
`define ADCOB_MIDSCALE  10'h200
// Conversion times in nanoseconds and the clock rate in megahertz.
`define ADCOB_CLK_MHZ   125
`define ADCOB_T_TEMP_NS 27000
`define ADCOB_T_ADC_NS  9000
// Cycle counts, rounded up so a conversion never ends early.
`define ADCOB_CYC_TEMP  ((`ADCOB_T_TEMP_NS * `ADCOB_CLK_MHZ + 999) / 1000)
`define ADCOB_CYC_ADC   ((`ADCOB_T_ADC_NS * `ADCOB_CLK_MHZ + 999) / 1000)
`endif

//--- rtl/adcob_pkg.sv
// Types shared by the converter control-byte and alarm block.
package adcob_pkg;
	// Conversion sequencer states.
	typedef enum logic {CONV_IDLE, CONV_RUN} adcob_conv_state_type;
endpackage

//--- rtl/adcob_top.sv
// Control-byte decoder, conversion timer and overtemperature alarm.
`timescale 1ns/1ns
`include "adcob_defs.svh"
// How it works
// R1: host configures only via one 8-bit write
// R2: upper five zero loads channel select
// R3: any upper bit set loads threshold
// R4: channel codes select sensor, inputs, bandgap
// R5: channel select resets to temperature sensor
// R6: compare result MSBs after temperature conversion
// R7: result above threshold drives alarm low
// R8: read end or lower result releases alarm
// R9: read end is rising read/write select
// R10: threshold equals alarm temperature plus 103
// R11: threshold resets to fifty degrees
// R12: bandgap conversion yields midscale code
// R13: host waits acquisition time between conversions
// R14: temperature conversion lasts 27 microseconds
// R15: codes 101, 110 stored, never alarm
module adcob_top
(
	input  wire logic       SYS_CLK,
	input  wire logic       RST,
	input  wire logic       SCLK,
	input  wire logic       DIN,
	input  wire logic       RD_WR,
	input  wire logic       CONVERT_START_N,
	input  wire logic [9:0] ADC_CODE,
	output logic      [2:0] CHAN_SEL,
	output logic      [7:0] ALARM_THRESHOLD,
	output logic            BUSY,
	output logic      [9:0] CONV_RESULT,
	output logic            OVERTEMP_ALARM_N
);

	// Link side: shift register, bit counter, held byte and event toggle.
	logic [7:0] shift_reg;
	logic [2:0] bit_cnt_reg;
	logic [7:0] byte_hold_reg;
	logic       byte_tgl_reg;

	// Shift the control byte in on rising serial clock during writes.
	// The count restarts on each rising serial clock while the select shows a read,
	// so a clocked read frame never leaves a partial byte behind.
	always_ff @(posedge SCLK or posedge RST)
	begin
		if (RST)
		begin
			shift_reg   <= 8'h00;
			bit_cnt_reg <= 3'h0;
		end
		else if (RD_WR)
		begin
			bit_cnt_reg <= 3'h0; // R1
		end
		else
		begin
			shift_reg   <= {shift_reg[6:0], DIN};
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
		end
	end

	// On the eighth bit the byte is frozen and a toggle announces it.
	// The held byte stays stable long after the toggle, so the system
	// side may read it without a per-bit crossing.
	always_ff @(posedge SCLK or posedge RST)
	begin
		if (RST)
		begin
			byte_hold_reg <= 8'h00;
			byte_tgl_reg  <= 1'b0;
		end
		else if (!RD_WR && bit_cnt_reg == 3'h7)
		begin
			byte_hold_reg <= {shift_reg[6:0], DIN}; // R1
			byte_tgl_reg  <= ~byte_tgl_reg;
		end
	end

	// Synchroniser stages for the toggle and the two pin levels.
	logic tgl_s1_reg, tgl_s2_reg, tgl_d_reg;
	logic rdw_s1_reg, rdw_s2_reg, rdw_d_reg;
	logic cst_s1_reg, cst_s2_reg, cst_d_reg;

	// Two flip-flops per crossing, then a third copy for edge detection.
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			{tgl_s1_reg, tgl_s2_reg, tgl_d_reg} <= 3'h0;
			{rdw_s1_reg, rdw_s2_reg, rdw_d_reg} <= 3'h0;
			{cst_s1_reg, cst_s2_reg, cst_d_reg} <= 3'h7;
		end
		else
		begin
			tgl_s1_reg <= byte_tgl_reg;
			tgl_s2_reg <= tgl_s1_reg;
			tgl_d_reg  <= tgl_s2_reg;
			rdw_s1_reg <= RD_WR;
			rdw_s2_reg <= rdw_s1_reg;
			rdw_d_reg  <= rdw_s2_reg;
			cst_s1_reg <= CONVERT_START_N;
			cst_s2_reg <= cst_s1_reg;
			cst_d_reg  <= cst_s2_reg;
		end
	end

	// One-cycle events on the system clock, and the upper-field test on the held byte.
	logic       byte_evt;
	logic       read_end;
	logic       conv_req;
	logic       upper_zero;
	assign byte_evt   = tgl_s2_reg ^ tgl_d_reg;
	assign read_end   = rdw_s2_reg & ~rdw_d_reg; // R9
	assign conv_req   = ~cst_s2_reg & cst_d_reg;
	assign upper_zero = (byte_hold_reg[7:`ADCOB_HI_LSB] == 5'h00);

	// Register file written by the control byte.
	logic [2:0] chan_reg;
	logic [7:0] thr_reg;

	// Route the byte by its upper five bits; the other register keeps.
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			chan_reg <= `ADCOB_CHAN_RST; // R5
			thr_reg  <= `ADCOB_THR_RST;  // R11
		end
		else if (byte_evt && upper_zero)
		begin
			chan_reg <= byte_hold_reg[`ADCOB_SEL_MSB:0]; // R2
		end
		else if (byte_evt)
		begin
			// The byte is stored raw; its offset coding is the host's job.
			thr_reg <= byte_hold_reg; // R3 R10
		end
	end

	// Conversion sequencer: state, cycle counter and the frozen channel.
	adcob_pkg::adcob_conv_state_type state_reg;
	logic [11:0] cnt_reg;
	logic [2:0]  conv_chan_reg;
	logic        done;
	assign done = (state_reg == adcob_pkg::CONV_RUN) && (cnt_reg == 12'h000);

	// Starts are ignored while busy. The channel is frozen at the start
	// so a write during conversion cannot mislabel the result.
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			state_reg     <= adcob_pkg::CONV_IDLE;
			cnt_reg       <= 12'h000;
			conv_chan_reg <= `ADCOB_CHAN_RST;
		end
		else
		begin
			case (state_reg)
				adcob_pkg::CONV_IDLE:
				begin
					if (conv_req)
					begin
						state_reg     <= adcob_pkg::CONV_RUN;
						conv_chan_reg <= chan_reg; // R4
						if (chan_reg == `ADCOB_CHAN_TEMP)
							cnt_reg <= 12'(`ADCOB_CYC_TEMP - 1); // R14
						else
							cnt_reg <= 12'(`ADCOB_CYC_ADC - 1);
					end
				end
				adcob_pkg::CONV_RUN:
				begin
					if (cnt_reg == 12'h000)
						state_reg <= adcob_pkg::CONV_IDLE;
					else
						cnt_reg <= cnt_reg - 12'h001;
				end
				default:
				begin
					state_reg <= adcob_pkg::CONV_IDLE;
				end
			endcase
		end
	end

	// Result and busy outputs, all registered.
	logic       busy_reg;
	logic [9:0] result_reg;

	// The bandgap selection reports midscale; other codes pass through.
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			busy_reg   <= 1'b0;
			result_reg <= 10'h000;
		end
		else
		begin
			busy_reg <= (state_reg == adcob_pkg::CONV_IDLE) ? conv_req : !done;
			if (done && conv_chan_reg == `ADCOB_CHAN_REF)
				result_reg <= `ADCOB_MIDSCALE; // R12
			else if (done)
				result_reg <= ADC_CODE; // R15
		end
	end

	// Comparison of the top eight result bits against the threshold.
	logic temp_done;
	logic over;
	logic under;
	assign temp_done = done && (conv_chan_reg == `ADCOB_CHAN_TEMP); // R6 R15
	assign over      = ADC_CODE[9:2] > thr_reg;
	assign under     = ADC_CODE[9:2] < thr_reg;

	// Alarm register. A new overtemperature wins over a read-end release
	// in the same cycle, so an event is never lost. Equal keeps the level.
	logic alarm_n_reg;
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			alarm_n_reg <= 1'b1;
		else if (temp_done && over)
			alarm_n_reg <= 1'b0; // R7
		else if (read_end || (temp_done && under))
			alarm_n_reg <= 1'b1; // R8
	end

	assign CHAN_SEL         = chan_reg;
	assign ALARM_THRESHOLD  = thr_reg;
	assign BUSY             = busy_reg;
	assign CONV_RESULT      = result_reg;
	assign OVERTEMP_ALARM_N = alarm_n_reg;

	// Helper counting busy cycles, read only by the timing check.
	logic [11:0] busy_len_reg;
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			busy_len_reg <= 12'h000;
		else if (!busy_reg)
			busy_len_reg <= 12'h000;
		else
			busy_len_reg <= busy_len_reg + 12'h001;
	end

	// Checks on the link side.
	property p_link_restart;
		@(posedge SCLK) disable iff (RST) RD_WR |=> bit_cnt_reg == 3'h0;
	endproperty
	a_link_restart: assert property (p_link_restart) else $error("bit count kept"); // R1

	// Checks on the system side.
	property p_chan_load;
		@(posedge SYS_CLK) disable iff (RST)
		byte_evt && upper_zero |=> chan_reg == $past(byte_hold_reg[2:0]) && $stable(thr_reg);
	endproperty
	a_chan_load: assert property (p_chan_load) else $error("channel not loaded"); // R2

	property p_thr_load;
		@(posedge SYS_CLK) disable iff (RST)
		byte_evt && !upper_zero |=> thr_reg == $past(byte_hold_reg) && $stable(chan_reg);
	endproperty
	a_thr_load: assert property (p_thr_load) else $error("threshold not loaded"); // R3

	property p_temp_time;
		@(posedge SYS_CLK) disable iff (RST)
		$fell(busy_reg) && conv_chan_reg == 3'h0 |-> $past(busy_len_reg) == 12'hd2e;
	endproperty
	a_temp_time: assert property (p_temp_time) else $error("conversion length wrong"); // R14

	property p_alarm_set;
		@(posedge SYS_CLK) disable iff (RST)
		temp_done && over |=> !alarm_n_reg [*1] ##1 (!alarm_n_reg || $past(read_end)
			|| $past(temp_done));
	endproperty
	a_alarm_set: assert property (p_alarm_set) else $error("alarm not raised"); // R7

	property p_alarm_low;
		@(posedge SYS_CLK) disable iff (RST) temp_done && under |=> alarm_n_reg;
	endproperty
	a_alarm_low: assert property (p_alarm_low) else $error("alarm not released"); // R8

	property p_read_clear;
		@(posedge SYS_CLK) disable iff (RST)
		$rose(rdw_s2_reg) && !(temp_done && over) |=> alarm_n_reg;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read end ignored"); // R9

	property p_ref_mid;
		@(posedge SYS_CLK) disable iff (RST)
		done && conv_chan_reg == 3'h7 |=> result_reg == 10'h200;
	endproperty
	a_ref_mid: assert property (p_ref_mid) else $error("bandgap code wrong"); // R12

	property p_other_quiet;
		@(posedge SYS_CLK) disable iff (RST)
		done && conv_chan_reg != 3'h0 && !read_end |=> $stable(alarm_n_reg);
	endproperty
	a_other_quiet: assert property (p_other_quiet) else $error("alarm moved"); // R15

	c_alarm: cover property (@(posedge SYS_CLK) disable iff (RST) $fell(alarm_n_reg));
	c_chan:  cover property (@(posedge SYS_CLK) disable iff (RST) byte_evt && upper_zero);
	c_thr:   cover property (@(posedge SYS_CLK) disable iff (RST) byte_evt && !upper_zero);
	c_ref:   cover property (@(posedge SYS_CLK) disable iff (RST) done && conv_chan_reg == 3'h7);

endmodule

//--- tb/adcob_host_model.sv
// Host model that writes control bytes and ends reads on the serial port.
`timescale 1ns/1ns
module adcob_host_model
(
	output logic sclk,
	output logic din,
	output logic rd_wr
);
	// The link clock stands low between frames.
	initial
	begin
		sclk = 1'b0;
		din = 1'b0;
		rd_wr = 1'b0;
	end
	// One byte, MSB first, 15 ns per bit; data moves while the clock is low.
	task automatic send_byte(input logic [7:0] b);
		rd_wr = 1'b0;
		#3;
		for (int i = 7; i >= 0; i--)
		begin
			din = b[i];
			#7 sclk = 1'b1;
			#8 sclk = 1'b0;
		end
		// Nobody holds the data line after the frame, so it shows the inverse.
		din = ~b[0];
	endtask
	// Part of a write frame that the host abandons after n bits, MSB first.
	task automatic cut_frame(input logic [7:0] b, input int n);
		rd_wr = 1'b0;
		#3;
		for (int i = 7; i > 7 - n; i--)
		begin
			din = b[i];
			#7 sclk = 1'b1;
			#8 sclk = 1'b0;
		end
	endtask
	// A read ends when the select goes back high.
	task automatic read_end();
		rd_wr = 1'b0;
		#100 rd_wr = 1'b1;
		// The host clocks a word out under read; these edges are no written bits.
		repeat (8)
		begin
			#7 sclk = 1'b1;
			#8 sclk = 1'b0;
		end
		#100;
	endtask
endmodule

//--- tb/tb_adcob_top.sv
// Self-checking bench for the control-byte and alarm block.
`timescale 1ns/1ns
module tb_adcob_top;
	logic       sys_clk;
	logic       rst;
	logic       cs_n;
	logic [9:0] adc_code;
	wire        sclk;
	wire        din;
	wire        rd_wr;
	wire  [2:0] chan_sel;
	wire  [7:0] thr;
	wire        busy;
	wire  [9:0] result;
	wire        alarm_n;
	int         n_errors;
	int         compares;
	int         cyc;
	logic [2:0] e_ch;
	logic [7:0] e_thr;
	logic       e_al;
	int         busy_run;
	int         busy_last;

	adcob_top u_dut (.SYS_CLK(sys_clk), .RST(rst), .SCLK(sclk), .DIN(din),
		.RD_WR(rd_wr), .CONVERT_START_N(cs_n), .ADC_CODE(adc_code),
		.CHAN_SEL(chan_sel), .ALARM_THRESHOLD(thr), .BUSY(busy),
		.CONV_RESULT(result), .OVERTEMP_ALARM_N(alarm_n));
	adcob_host_model u_host (.sclk(sclk), .din(din), .rd_wr(rd_wr));

	// System clock, 8 ns.
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// A hang is cut short well above the expected run of about 27500 cycles.
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_errors++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Length of the latest busy pulse, counted at falling edges where busy is settled.
	// Counting from the first busy cycle keeps the start latency out of the measure.
	always @(negedge sys_clk)
	begin
		if (busy === 1'b1)
			busy_run++;
		else if (busy_run != 0)
		begin
			busy_last = busy_run;
			busy_run = 0;
		end
	end

	task automatic chk(input string nm, input logic [11:0] g, input logic [11:0] e);
		compares++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// Threshold code for an alarm temperature in whole degrees.
	function automatic logic [7:0] thr_of(input logic [7:0] t);
		return t + 8'h67;
	endfunction
	// Write a byte and check where it was routed.
	task automatic wr(input logic [7:0] b);
		u_host.send_byte(b);
		if (b[7:3] == 5'h0)
			e_ch = b[2:0];
		else
			e_thr = b;
		repeat (8) @(posedge sys_clk);
		chk("chan", {9'h0, chan_sel}, {9'h0, e_ch});
		chk("thr", {4'h0, thr}, {4'h0, e_thr});
	endtask
	// Run one conversion and check its length, result and the alarm.
	task automatic conv(input logic [9:0] code);
		int n;
		repeat (60) @(posedge sys_clk);
		busy_last = 0;
		adc_code <= code;
		cs_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		cs_n <= 1'b1;
		@(negedge sys_clk);
		n = 0;
		while (busy === 1'b1 && n < 4000)
		begin
			@(negedge sys_clk);
			n++;
		end
		// One more falling edge so the pulse length has been latched.
		@(negedge sys_clk);
		chk("busy", 12'(busy_last), (e_ch == 3'h0) ? 12'hd2f : 12'h465);
		chk("result", {2'h0, result}, {2'h0, (e_ch == 3'h7) ? 10'h200 : code});
		// Only the sensor channel moves the alarm; equality leaves it alone.
		if (e_ch == 3'h0 && code[9:2] > e_thr)
			e_al = 1'b0;
		else if (e_ch == 3'h0 && code[9:2] < e_thr)
			e_al = 1'b1;
		chk("alarm", {11'h0, alarm_n}, {11'h0, e_al});
	endtask

	initial
	begin
		n_errors = 0;
		compares = 0;
		cyc = 0;
		rst = 1'b1;
		cs_n = 1'b1;
		adc_code = 10'h0;
		e_ch = 3'h0;
		e_thr = 8'h99;
		e_al = 1'b1;
		void'($urandom(33619));
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk("chan", {9'h0, chan_sel}, 12'h0);
		chk("thr", {4'h0, thr}, 12'h99);
		chk("alarm", {11'h0, alarm_n}, 12'h1);
		$display("test reset done");
		wr(8'h07);
		wr(8'h08);
		wr(8'h05);
		wr(8'h06);
		// An abandoned write followed by a clocked read must leave no partial byte.
		u_host.cut_frame(8'hff, 3);
		u_host.read_end();
		wr(8'h03);
		for (int i = 0; i < 12; i++)
			wr(8'($urandom));
		$display("test bytes done");
		for (int c = 0; c < 8; c++)
		begin
			wr({5'h0, 3'(c)});
			conv(10'($urandom));
		end
		$display("test channels done");
		wr(thr_of(8'h32));
		wr(8'h00);
		conv({8'h9a, 2'h3});
		conv({8'h99, 2'h0});
		u_host.read_end();
		repeat (8) @(posedge sys_clk);
		e_al = 1'b1;
		chk("alarm", {11'h0, alarm_n}, 12'h1);
		conv({8'ha0, 2'h1});
		wr(8'h05);
		conv(10'h3ff);
		wr(8'h00);
		conv({8'h98, 2'h2});
		$display("test alarm done");
		complete_run();
	end
endmodule
